/* rtl/lmhp_regs.svh */
`ifndef LMHP_REGS_SVH
`define LMHP_REGS_SVH
`define LMHP_A_SCSI_DATA 8'h40
`define LMHP_A_PHASE 8'h42
`define LMHP_A_FIFO 8'h4A
`define LMHP_A_BUF_DATA 8'h50
`define LMHP_A_PIO 8'h52
`define LMHP_A_BUF_OUT 8'h53
`define LMHP_A_PTR0 8'h57
`define LMHP_A_PTR1 8'h58
`define LMHP_A_PTR2 8'h59
`define LMHP_A_WAIT 8'h5A
`define LMHP_A_STATUS 8'h79
`define LMHP_WAIT_MAX 4'hF
`define LMHP_B_INHIBIT 4
`define LMHP_B_BYTE_RDY 7
`define LMHP_B_DIR 3
`define LMHP_B_GO 2
`define LMHP_B_SYNC 1
`define LMHP_B_REQ 3
`define LMHP_B_ACK 4
`define LMHP_B_DRV 7
`define LMHP_FIFO_DEPTH 16
`define LMHP_PTR_STEP 24'h000001
`define LMHP_F_CNT_HI 7
`define LMHP_F_CNT_LO 4
`define LMHP_F_WAIT_HI 3
`define LMHP_F_PH_HI 2
`endif

/* rtl/lmhp_pkg.sv */
package lmhp_pkg;
	typedef enum logic [1:0] {
		PIO_IDLE,
		PIO_REQ,
		PIO_ACK_OFF
	} lmhp_pio_state_t;

	typedef struct packed {
		logic        we;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} lmhp_buf_req_t;
endpackage

/* rtl/lmhp_host_port.sv */
`timescale 1ns/1ns
`include "lmhp_regs.svh"

module lmhp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push) mem_q[wr_q] <= in_data;
	end
endmodule

module lmhp_host_port (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   ad_in,
	output logic [7:0]        ad_out,
	output logic              ad_oe,
	input  wire logic         addr_latch_en,
	input  wire logic         chip_select_n,
	input  wire logic         write_strobe_or_direction,
	input  wire logic         read_strobe_or_data_strobe,
	input  wire logic         bus_style_select,
	output logic              ready,
	output lmhp_pkg::lmhp_buf_req_t buf_req,
	output logic              buf_req_valid,
	input  wire logic         buf_gnt,
	input  wire logic [7:0]   buf_rdata,
	input  wire logic         dram_mode,
	input  wire logic         mem_oe_n_raw,
	input  wire logic         row_strobe_raw,
	input  wire logic         column_strobe_raw,
	output logic              buffer_output_enable_n,
	output logic              buffer_addr16_or_row_strobe,
	output logic              buffer_addr17_or_column_strobe,
	input  wire logic [7:0]   scsi_db_in,
	output logic [7:0]        scsi_db_out,
	output logic              scsi_db_oe,
	input  wire logic         scsi_req_in,
	input  wire logic         scsi_ack_in,
	output logic              scsi_req_out,
	output logic [2:0]        scsi_phase
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rs1_q;
	logic rst_s_n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q   <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rs1_q   <= 1'b1;
			rst_s_n <= rs1_q;
		end
	end

	// ------------------------------------------------------------
	// Strobe decode
	// ------------------------------------------------------------
	logic       rd_act_q;
	logic       wr_act_q;
	logic [7:0] addr_q;
	wire        sep_mode = bus_style_select;
	wire        sel      = ~chip_select_n;
	wire        dstb     = read_strobe_or_data_strobe;
	wire        rw       = write_strobe_or_direction;
	wire        rd_act   = sep_mode ? ~dstb : (dstb & rw);
	wire        wr_act   = sep_mode ? ~rw : (dstb & ~rw);
	wire        rd_start = rd_act & ~rd_act_q & sel;
	// Writes are taken at strobe end: wr rise, or ds fall with rw low.
	wire        wr_take  = wr_act_q & ~wr_act & sel;
	wire        acc_start = (rd_act | wr_act) & ~(rd_act_q | wr_act_q) & sel;

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
			addr_q   <= 8'h00;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
			if (addr_latch_en) addr_q <= ad_in;
		end
	end

	wire hit_scsi  = (addr_q == `LMHP_A_SCSI_DATA);
	wire hit_phase = (addr_q == `LMHP_A_PHASE);
	wire hit_fifo  = (addr_q == `LMHP_A_FIFO);
	wire hit_bdata = (addr_q == `LMHP_A_BUF_DATA);
	wire hit_pio   = (addr_q == `LMHP_A_PIO);
	wire hit_bout  = (addr_q == `LMHP_A_BUF_OUT);
	wire hit_p0    = (addr_q == `LMHP_A_PTR0);
	wire hit_p1    = (addr_q == `LMHP_A_PTR1);
	wire hit_p2    = (addr_q == `LMHP_A_PTR2);
	wire hit_wait  = (addr_q == `LMHP_A_WAIT);
	wire hit_stat  = (addr_q == `LMHP_A_STATUS);

	// ------------------------------------------------------------
	// Wait states
	// ------------------------------------------------------------
	logic [3:0] wait_q;
	logic [3:0] wcnt_q;
	assign ready = ~(acc_start & (wait_q != 4'h0)) & (wcnt_q == 4'h0);

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			wait_q <= `LMHP_WAIT_MAX;
			wcnt_q <= 4'h0;
		end else begin
			if (wr_take & hit_wait) wait_q <= ad_in[`LMHP_F_WAIT_HI:0];
			if (acc_start & (wait_q != 4'h0)) wcnt_q <= wait_q - 4'h1;
			else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0]  phase_q;
	logic [7:0]  direct_q;
	logic [7:0]  bout_q;
	logic [23:0] ptr_q;
	logic [3:0]  cnt_q;
	logic        dir_q;
	logic        go_q;
	logic        sync_q;
	logic [7:0]  bdata_q;
	logic        byte_rdy_q;
	lmhp_pkg::lmhp_pio_state_t st_q;

	wire ptr_wr   = wr_take & (hit_p0 | hit_p1 | hit_p2);
	wire pio_wr   = wr_take & hit_pio;
	wire buf_done = buf_gnt & buf_req_valid;
	wire inhibit  = bout_q[`LMHP_B_INHIBIT];
	// A new buffer port access clears byte ready; a completion the same cycle wins.
	wire bdata_clr = (wr_take | rd_start) & hit_bdata;

	// ------------------------------------------------------------
	// Auto transfer FIFO
	// ------------------------------------------------------------
	logic       f_in_ready;
	logic       f_out_valid;
	logic [7:0] f_out_data;
	wire        eng_xfer  = (st_q == lmhp_pkg::PIO_REQ) & scsi_ack_in;
	wire        host_push = wr_take & hit_fifo & ~dir_q;
	wire        host_pop  = rd_start & hit_fifo & dir_q;
	wire        f_in_valid  = dir_q ? eng_xfer : host_push;
	wire [7:0]  f_in_data   = dir_q ? scsi_db_in : ad_in;
	wire        f_out_ready = dir_q ? host_pop : eng_xfer;

	lmhp_fifo #(
		.WIDTH (8),
		.DEPTH (`LMHP_FIFO_DEPTH)
	) u_fifo (
		.clk       (sys_clk),
		.rst_n     (rst_s_n),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// The engine raises REQ only when the FIFO can take or give a byte.
	wire eng_can = dir_q ? f_in_ready : f_out_valid;

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			st_q <= lmhp_pkg::PIO_IDLE;
		end else begin
			case (st_q)
				lmhp_pkg::PIO_IDLE: begin
					if (go_q & (cnt_q != 4'h0) & eng_can) st_q <= lmhp_pkg::PIO_REQ;
				end
				lmhp_pkg::PIO_REQ: begin
					// Sync mode does not wait for ACK release between bytes.
					if (scsi_ack_in) st_q <= sync_q ? lmhp_pkg::PIO_IDLE : lmhp_pkg::PIO_ACK_OFF;
				end
				lmhp_pkg::PIO_ACK_OFF: begin
					if (!scsi_ack_in) st_q <= lmhp_pkg::PIO_IDLE;
				end
				default: st_q <= lmhp_pkg::PIO_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			phase_q  <= 8'h00;
			direct_q <= 8'h00;
			bout_q   <= 8'h00;
		end else if (wr_take) begin
			if (hit_phase) phase_q <= ad_in;
			if (hit_scsi) direct_q <= ad_in;
			if (hit_bout) bout_q <= ad_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cnt_q  <= 4'h0;
			dir_q  <= 1'b0;
			go_q   <= 1'b0;
			sync_q <= 1'b0;
		end else if (pio_wr) begin
			cnt_q  <= ad_in[`LMHP_F_CNT_HI:`LMHP_F_CNT_LO];
			dir_q  <= ad_in[`LMHP_B_DIR];
			go_q   <= ad_in[`LMHP_B_GO];
			sync_q <= ad_in[`LMHP_B_SYNC];
		end else begin
			if (eng_xfer) cnt_q <= cnt_q - 4'h1;
			if ((st_q == lmhp_pkg::PIO_IDLE) & (cnt_q == 4'h0)) go_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Buffer data port
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			buf_req_valid <= 1'b0;
			buf_req       <= '0;
			bdata_q       <= 8'h00;
			byte_rdy_q    <= 1'b0;
			ptr_q         <= 24'h000000;
		end else begin
			byte_rdy_q <= buf_done | (byte_rdy_q & ~bdata_clr);
			if (wr_take & hit_bdata) begin
				buf_req_valid <= 1'b1;
				buf_req.we    <= 1'b1;
				buf_req.wdata <= ad_in;
			end else if (rd_start & hit_bdata) begin
				buf_req_valid <= 1'b1;
				buf_req.we    <= 1'b0;
			end else if (buf_done) begin
				buf_req_valid <= 1'b0;
			end
			if (buf_done & ~buf_req.we) bdata_q <= buf_rdata;
			if (ptr_wr) begin
				if (hit_p0) ptr_q[7:0] <= ad_in;
				if (hit_p1) ptr_q[15:8] <= ad_in;
				if (hit_p2) ptr_q[23:16] <= ad_in;
			end else if (buf_done) begin
				ptr_q <= ptr_q + `LMHP_PTR_STEP;
			end
			buf_req.addr <= ptr_wr ? buf_req.addr : ptr_q;
		end
	end

	// ------------------------------------------------------------
	// Read path and pins
	// ------------------------------------------------------------
	wire [7:0] phase_rd = {phase_q[`LMHP_B_DRV], scsi_ack_in, scsi_req_in, phase_q[`LMHP_B_ACK:0]};
	wire [7:0] pio_rd   = {cnt_q, dir_q, go_q, sync_q, 1'b0};
	wire [7:0] rd_mux   = hit_scsi  ? scsi_db_in :
	                      hit_phase ? phase_rd :
	                      hit_fifo  ? f_out_data :
	                      hit_bdata ? bdata_q :
	                      hit_pio   ? pio_rd :
	                      hit_bout  ? bout_q :
	                      hit_p0    ? ptr_q[7:0] :
	                      hit_p1    ? ptr_q[15:8] :
	                      hit_p2    ? ptr_q[23:16] :
	                      hit_wait  ? {4'h0, wait_q} :
	                      hit_stat  ? {byte_rdy_q, 7'h00} : 8'h00;

	// Read data freezes while a read is active so a prefetch cannot disturb it.
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) ad_out <= 8'h00;
		else if (!rd_act_q) ad_out <= rd_mux;
	end

	assign ad_oe = rd_act & sel & rd_act_q;

	wire eng_wr = go_q & ~dir_q;
	assign scsi_req_out = phase_q[`LMHP_B_REQ] | (st_q == lmhp_pkg::PIO_REQ);
	assign scsi_phase   = phase_q[`LMHP_F_PH_HI:0];
	assign scsi_db_out  = eng_wr ? f_out_data : direct_q;
	assign scsi_db_oe   = phase_q[`LMHP_B_DRV] | eng_wr;

	assign buffer_output_enable_n         = mem_oe_n_raw | inhibit;
	assign buffer_addr16_or_row_strobe    = row_strobe_raw | (inhibit & dram_mode);
	assign buffer_addr17_or_column_strobe = column_strobe_raw | (inhibit & dram_mode);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_s_n);

	sequence s_fetch_done;
		buf_done && !buf_req.we;
	endsequence
	sequence s_byte_ready;
		byte_rdy_q && (bdata_q == $past(buf_rdata));
	endsequence

	property p_ready_wait;
		acc_start && (wait_q != 4'h0) |-> !ready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready high at start");

	property p_max_wait;
		acc_start && (wait_q == `LMHP_WAIT_MAX) |-> !ready [*8];
	endproperty
	a_max_wait: assert property (p_max_wait) else $error("max wait too short");

	property p_dir_drive;
		!sep_mode && ad_oe |-> dstb && rw;
	endproperty
	a_dir_drive: assert property (p_dir_drive) else $error("drive without data strobe");

	property p_sep_drive;
		sep_mode && ad_oe |-> !dstb;
	endproperty
	a_sep_drive: assert property (p_sep_drive) else $error("drive without rd");

	property p_buf_write;
		wr_take && hit_bdata |=> buf_req_valid && buf_req.we && (buf_req.wdata == $past(ad_in));
	endproperty
	a_buf_write: assert property (p_buf_write) else $error("no write request");

	property p_prefetch;
		rd_start && hit_bdata |=> buf_req_valid && !buf_req.we;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no prefetch");

	property p_fetch_ready;
		s_fetch_done |=> s_byte_ready;
	endproperty
	a_fetch_ready: assert property (p_fetch_ready) else $error("byte not ready");

	property p_ptr_inc;
		buf_done && !ptr_wr |=> ptr_q == $past(ptr_q) + `LMHP_PTR_STEP;
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not bumped");

	property p_inhibit;
		inhibit |-> buffer_output_enable_n;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("oe not inhibited");

	property p_go_clear;
		(st_q == lmhp_pkg::PIO_IDLE) && (cnt_q == 4'h0) && !pio_wr |=> !go_q;
	endproperty
	a_go_clear: assert property (p_go_clear) else $error("go stuck");
endmodule

/* verif/lmhp_buf_mem_model.sv */
`timescale 1ns/1ns
module lmhp_buf_mem_model (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire lmhp_pkg::lmhp_buf_req_t req,
	input  wire logic                    req_valid,
	input  wire logic [1:0]              lat,
	output logic                         gnt,
	output logic [7:0]                   rdata
);
	// ----------------------------------------
	// Arbiter and buffer memory
	// ----------------------------------------
	logic [7:0] mem [0:255];
	logic [1:0] wait_q;

	// Between grants the read bus is released, so it toggles rather than holding a byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gnt    <= 1'b0;
			rdata  <= 8'hA5;
			wait_q <= 2'h0;
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'h00;
		end else begin
			gnt   <= 1'b0;
			rdata <= ~rdata;
			if (req_valid && !gnt && wait_q >= lat) begin
				gnt    <= 1'b1;
				wait_q <= 2'h0;
				if (req.we)
					mem[req.addr[7:0]] <= req.wdata;
				else
					rdata <= mem[req.addr[7:0]];
			end else if (req_valid && !gnt) begin
				wait_q <= wait_q + 2'h1;
			end
		end
	end
endmodule

/* verif/local_mcu_host_port_tb.sv */
`timescale 1ns/1ns
module local_mcu_host_port_tb;
	// ----------------------------------------
	// Stimulus, monitor and verdict
	// ----------------------------------------
	logic                    sys_clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [7:0]              ad_in = 8'h00;
	logic                    ale = 1'b0;
	logic                    cs_n = 1'b1;
	logic                    wr = 1'b1;
	logic                    rd = 1'b1;
	logic                    sel = 1'b1;
	logic                    dram_mode = 1'b0;
	logic [2:0]              raw = 3'h7;
	logic [7:0]              db_in = 8'h00;
	logic                    req_in = 1'b0;
	logic                    ack_in = 1'b0;
	logic [1:0]              lat = 2'h0;
	logic [7:0]              ad_out, db_out, rv, nw, got, p, d0, x;
	logic                    ad_oe, ready, buf_req_valid, gnt, db_oe, req_out;
	logic                    oe_n, row_s, col_s, oe_s;
	logic [2:0]              phase;
	logic [7:0]              rdata;
	lmhp_pkg::lmhp_buf_req_t buf_req;
	logic [7:0]              fb [0:16];
	logic [7:0]              exp_q [$];
	int                      fail_count = 0;
	int                      cmp_count = 0;
	int                      cyc = 0;
	int                      moved = 0;
	bit                      scsi_on = 0;
	bit                      cap = 0;
	event                    got_e;

	always #25 sys_clk = ~sys_clk;

	lmhp_host_port DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
		.addr_latch_en(ale), .chip_select_n(cs_n), .write_strobe_or_direction(wr),
		.read_strobe_or_data_strobe(rd), .bus_style_select(sel), .ready(ready),
		.buf_req(buf_req), .buf_req_valid(buf_req_valid), .buf_gnt(gnt), .buf_rdata(rdata),
		.dram_mode(dram_mode), .mem_oe_n_raw(raw[2]), .row_strobe_raw(raw[1]),
		.column_strobe_raw(raw[0]), .buffer_output_enable_n(oe_n),
		.buffer_addr16_or_row_strobe(row_s), .buffer_addr17_or_column_strobe(col_s),
		.scsi_db_in(db_in), .scsi_db_out(db_out), .scsi_db_oe(db_oe), .scsi_req_in(req_in),
		.scsi_ack_in(ack_in), .scsi_req_out(req_out), .scsi_phase(phase)
	);

	lmhp_buf_mem_model MEM (
		.clk(sys_clk), .rst_n(rst_n), .req(buf_req), .req_valid(buf_req_valid),
		.lat(lat), .gnt(gnt), .rdata(rdata)
	);

	// Once scsi_on is set, the far SCSI party acknowledges one cycle after each request edge.
	always @(posedge sys_clk) begin
		ack_in <= scsi_on & req_out;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end

	always @(negedge sys_clk) begin
		if (scsi_on && req_out === 1'b1 && ack_in === 1'b1) begin
			moved++;
			if (cap)
				seen(db_out);
		end
	end

	always @(got_e) begin
		if (exp_q.size() == 0)
			cmp(got, 8'hxx);
		else
			cmp(got, exp_q.pop_front());
	end

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic seen(input logic [7:0] v);
		got = v;
		->got_e;
		// The pause lets the monitor take this value before the next one lands.
		#1;
	endtask

	task automatic expect_now(input logic [7:0] g, input logic [7:0] e);
		exp_q.push_back(e);
		seen(g);
	endtask

	// One access: address phase, one strobe held through the wait states, one idle cycle.
	task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		nw = 8'h00;
		@(posedge sys_clk);
		ale   <= 1'b1;
		ad_in <= a;
		cs_n  <= 1'b0;
		@(posedge sys_clk);
		ale   <= 1'b0;
		ad_in <= we ? d : ~a;
		@(posedge sys_clk);
		wr <= !we;
		rd <= sel ? we : 1'b1;
		do begin
			@(negedge sys_clk);
			n++;
			if (ready === 1'b0)
				nw++;
		end while ((ready !== 1'b1 || n < 3) && n < 40);
		rv   = ad_out;
		oe_s = ad_oe;
		@(posedge sys_clk);
		rd <= sel;
		if (sel)
			wr <= 1'b1;
		@(posedge sys_clk);
		cs_n <= 1'b1;
		wr   <= 1'b1;
		@(negedge sys_clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(1'b0, a, 8'h00);
		seen(rv);
		expect_now({7'h00, oe_s}, 8'h01);
	endtask

	task automatic settle();
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 20 && buf_req_valid !== 1'b0; i++)
			@(posedge sys_clk);
	endtask

	task automatic wait_moved(input int k);
		for (int i = 0; i < 300 && moved < k; i++)
			@(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic summarize();
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		void'($urandom(34));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdc(8'h79, 8'h00);
		expect_now(nw, 8'h0F);
		wr_wait(8'h03);
		wr_wait(8'h00);
		@(posedge sys_clk);
		p  = 8'($urandom_range(0, 252));
		d0 = 8'($urandom);
		x  = 8'($urandom);
		lat <= 2'($urandom_range(1, 3));
		acc(1'b1, 8'h57, p);
		acc(1'b1, 8'h58, 8'h00);
		acc(1'b1, 8'h59, 8'h00);
		acc(1'b1, 8'h50, d0);
		settle();
		rdc(8'h79, 8'h80);
		acc(1'b1, 8'h50, x);
		settle();
		rdc(8'h57, p + 8'h02);
		acc(1'b1, 8'h57, p);
		acc(1'b0, 8'h50, 8'h00);
		settle();
		rdc(8'h79, 8'h80);
		rdc(8'h50, d0);
		settle();
		rdc(8'h50, x);
		settle();
		rdc(8'h57, p + 8'h03);
		@(posedge sys_clk);
		dram_mode <= 1'b1;
		raw       <= 3'h0;
		acc(1'b1, 8'h53, 8'h10);
		expect_now({5'h00, oe_n, row_s, col_s}, 8'h07);
		@(posedge sys_clk);
		dram_mode <= 1'b0;
		@(negedge sys_clk);
		expect_now({5'h00, oe_n, row_s, col_s}, 8'h04);
		acc(1'b1, 8'h53, 8'h00);
		expect_now({5'h00, oe_n, row_s, col_s}, 8'h00);
		@(posedge sys_clk);
		sel    <= 1'b0;
		rd     <= 1'b0;
		db_in  <= x;
		req_in <= 1'b1;
		acc(1'b1, 8'h40, d0);
		expect_now(db_out, d0);
		rdc(8'h40, x);
		acc(1'b1, 8'h42, 8'h8D);
		expect_now({db_oe, req_out, 3'h0, phase}, 8'hC5);
		rdc(8'h42, 8'hAD);
		acc(1'b1, 8'h42, 8'h00);
		rdc(8'h41, 8'h00);
		acc(1'b1, 8'h52, 8'h00);
		for (int i = 0; i < 17; i++) begin
			fb[i] = 8'($urandom);
			acc(1'b1, 8'h4A, fb[i]);
		end
		for (int i = 0; i < 15; i++)
			exp_q.push_back(fb[i]);
		scsi_on = 1;
		cap     = 1;
		acc(1'b1, 8'h52, 8'hF4);
		wait_moved(15);
		rdc(8'h52, 8'h00);
		exp_q.push_back(fb[15]);
		acc(1'b1, 8'h52, 8'h16);
		wait_moved(16);
		cap = 0;
		acc(1'b1, 8'h52, 8'h2C);
		wait_moved(18);
		rdc(8'h4A, x);
		rdc(8'h4A, x);
		summarize();
	end

	task automatic wr_wait(input logic [7:0] w);
		acc(1'b1, 8'h5A, w);
		rdc(8'h79, 8'h00);
		expect_now(nw, w);
	endtask
endmodule
